// ==== slc_lcd_ctrl.sv ====
/*
  segment lcd control and status registers with frame sequencer.
  assumes an avalon-mm master, an lcd clock input sampled in core_clk,
  and analog drivers that act on the panel control word.
*/
// Functional notes
// - enable starts driving; clearing enable stops everything at once
// - while disabled, common and segment pins return to port function
// - waveform bit picks default or low-power form, applied at next frame
// - frame flag sets together with each data latch at frame start
// - interrupt request needs flag, frame interrupt enable and global enable
// - flag clears on vector taken or writing one; zero leaves it
// - low-power waveform sets flag only every second frame
// - reserved bits of control and frame-rate registers read zero
// - buffer-disable bit switches off and bypasses level buffers
// - supply-disable bit switches off internal supply; external drive expected
// - blanking finishes current frame, or current low-power frame pair, then grounds all pins
// - clock select: system clock at zero, asynchronous source at one
// - multiplexed duty: bias bit gives one-third at zero, half at one
// - duty field selects static, 1/2, 1/3, 1/4 with 1-4 commons
// - static duty always static bias; others use bias bit
// - port mask enables 13 up to 25 segment pins
// - prescaler tap divides lcd clock by 16 up to 4096
// - prescaler output passes extra divider giving prescaled panel clock
// - clock divide field divides by code plus one
// - frame is 8 prescaled periods, or 6 for 1/3 duty, times divider
// - blanking and waveform copies captured just before each frame, only every second one under low-power waveform
`timescale 1ns/1ps
`default_nettype none
module slc_lcd_ctrl (
  input  wire logic                      core_clk,
  input  wire logic                      rst,
  input  wire logic [slc_pkg::ADDR_W-1:0] avs_address,
  input  wire logic                      avs_read,
  input  wire logic                      avs_write,
  input  wire logic [31:0]               avs_writedata,
  input  wire logic [3:0]                avs_byteenable,
  output var  logic [31:0]               avs_readdata,
  output var  logic                      avs_waitrequest,
  input  wire logic                      async_clk_in,
  input  wire logic                      global_irq_enable,
  input  wire logic                      irq_ack,
  output var  logic                      frame_irq,
  output var  logic                      data_latch,
  output var  slc_pkg::slc_panel_t       panel
);
  import slc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // registers

  slc_ctrl_a_t     ctrl_a_reg,  ctrl_a_next;
  slc_ctrl_b_t     ctrl_b_reg,  ctrl_b_next;
  slc_frame_rate_t fr_reg,      fr_next;
  logic [31:0]     rdata_reg,   rdata_next;
  logic            wait_reg,    wait_next;
  slc_state_t      st_reg,      st_next;
  logic [2:0]      phase_reg,   phase_next;
  logic            parity_reg,  parity_next;
  logic            blank_wc_reg, blank_wc_next;
  logic            lp_wc_reg,   lp_wc_next;
  logic            irq_reg,     irq_next;
  logic            latch_reg,   latch_next;
  slc_panel_t      panel_reg,   panel_next;
  logic            async_s1_reg, async_s2_reg, async_s3_reg;

  logic            req;
  logic            wr_ok;
  logic            flag_clr;
  logic            boundary;
  logic            latch;
  logic            run_next;
  logic            lcd_tick;
  logic            ps_tick;
  logic [2:0]      last_phase;
  logic [1:0]      shift;
  logic [2:0]      com_idx;
  logic [NSEG-1:0] seg_en_next;
  logic [NCOM-1:0] com_en_next;
  slc_ctrl_a_t     wr_a;

  ////////////////////////////////////////////////////////////////////////////
  // lcd clock source

  // first stage feeds only the second; edge found on later stages
  always_ff @(posedge core_clk) begin
    if (rst) begin
      async_s1_reg <= 1'b0;
      async_s2_reg <= 1'b0;
      async_s3_reg <= 1'b0;
    end else begin
      async_s1_reg <= async_clk_in;
      async_s2_reg <= async_s1_reg;
      async_s3_reg <= async_s2_reg;
    end
  end

  // async source must be slower than half of core_clk
  assign lcd_tick = ctrl_b_reg.clock_source_sel ? (async_s2_reg && !async_s3_reg) : 1'b1;

  slc_prescaler u_prescaler (
    .core_clk (core_clk),
    .rst      (rst),
    .run      (ctrl_a_reg.controller_enable),
    .lcd_tick (lcd_tick),
    .tap_sel  (fr_reg.prescaler_tap_sel),
    .div_sel  (fr_reg.clock_divide_sel),
    .ps_tick  (ps_tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // pin ownership, one entry per pin

  genvar gi;
  generate
    for (gi = 0; gi < NSEG; gi++) begin : g_seg
      assign seg_en_next[gi] = run_next && (5'(gi) <= SEG_LAST[ctrl_b_reg.segment_port_mask]);
    end
    for (gi = 0; gi < NCOM; gi++) begin : g_com
      assign com_en_next[gi] = run_next && (2'(gi) <= ctrl_b_reg.duty_sel);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus, registers and frame sequencer

  always_comb begin
    req           = avs_read || avs_write;
    wr_ok         = avs_write && !wait_reg && avs_byteenable[0];
    wr_a          = slc_ctrl_a_t'(avs_writedata[7:0]);
    wait_next     = !(req && wait_reg);
    rdata_next    = rdata_reg;
    ctrl_a_next   = ctrl_a_reg;
    ctrl_b_next   = ctrl_b_reg;
    fr_next       = fr_reg;
    st_next       = st_reg;
    phase_next    = phase_reg;
    parity_next   = parity_reg;
    blank_wc_next = blank_wc_reg;
    lp_wc_next    = lp_wc_reg;
    boundary      = 1'b0;
    run_next      = 1'b0;

    // one wait cycle per access; unmapped reads return zero
    if (avs_read && wait_reg) begin
      case (avs_address)
        ADR_CTRL_A:     rdata_next = {24'h000000, ctrl_a_reg & MASK_CTRL_A};
        ADR_CTRL_B:     rdata_next = {24'h000000, ctrl_b_reg & MASK_CTRL_B};
        ADR_FRAME_RATE: rdata_next = {24'h000000, fr_reg & MASK_FRAME_RATE};
        default:        rdata_next = 32'h00000000;
      endcase
    end

    flag_clr = irq_ack || (wr_ok && avs_address == ADR_CTRL_A && wr_a.frame_flag);
    if (wr_ok && avs_address == ADR_CTRL_A) begin
      ctrl_a_next            = wr_a & MASK_CTRL_A;
      ctrl_a_next.frame_flag = ctrl_a_reg.frame_flag;
    end
    if (wr_ok && avs_address == ADR_CTRL_B) begin
      ctrl_b_next = slc_ctrl_b_t'(avs_writedata[7:0] & MASK_CTRL_B);
    end
    if (wr_ok && avs_address == ADR_FRAME_RATE) begin
      fr_next = slc_frame_rate_t'(avs_writedata[7:0] & MASK_FRAME_RATE);
    end

    last_phase = (ctrl_b_reg.duty_sel == DUTY_THIRD) ? LAST_K6 : LAST_K8;
    case (st_reg)
      ST_IDLE: begin
        phase_next  = 3'h0;
        parity_next = 1'b0;
        if (ctrl_a_reg.controller_enable) begin
          st_next  = ST_RUN;
          boundary = 1'b1;
        end
      end
      ST_RUN: begin
        if (!ctrl_a_reg.controller_enable) begin
          st_next    = ST_IDLE;
          phase_next = 3'h0;
        end else if (ps_tick) begin
          if (phase_reg >= last_phase) begin
            phase_next = 3'h0;
            boundary   = 1'b1;
          end else begin
            phase_next = phase_reg + 3'h1;
          end
        end
      end
      default: begin
        st_next    = ST_IDLE;
        phase_next = 3'h0;
      end
    endcase

    // low-power waveform needs two equal frames, so latch every other one
    latch = boundary && (!ctrl_a_reg.low_power_waveform_sel || !parity_reg);
    if (boundary) begin
      parity_next = ctrl_a_reg.low_power_waveform_sel ? !parity_reg : 1'b0;
    end
    if (latch) begin
      blank_wc_next = ctrl_a_reg.blanking;
      lp_wc_next    = ctrl_a_reg.low_power_waveform_sel;
    end

    // hardware set wins over any clear in the same cycle
    if (latch) begin
      ctrl_a_next.frame_flag = 1'b1;
    end else if (flag_clr) begin
      ctrl_a_next.frame_flag = 1'b0;
    end
    latch_next = latch;
    irq_next   = ctrl_a_next.frame_flag && ctrl_a_reg.frame_irq_enable && global_irq_enable;

    run_next = (st_next == ST_RUN);
    case (ctrl_b_reg.duty_sel)
      DUTY_STATIC: shift = SHIFT_STATIC;
      DUTY_HALF:   shift = SHIFT_HALF;
      default:     shift = SHIFT_MULTI;
    endcase
    com_idx = phase_next >> shift;

    panel_next         = '0;
    panel_next.seg_en  = seg_en_next;
    panel_next.com_en  = com_en_next;
    panel_next.com_sel = run_next ? (4'h1 << com_idx[1:0]) : 4'h0;
    panel_next.blank   = run_next && blank_wc_next;
    panel_next.lp_wave = lp_wc_next;
    if (ctrl_b_reg.duty_sel == DUTY_STATIC) begin
      panel_next.bias = BIAS_STATIC;
    end else begin
      panel_next.bias = ctrl_b_reg.half_bias_sel ? BIAS_HALF : BIAS_THIRD;
    end
    panel_next.buf_off    = ctrl_a_reg.buffer_disable;
    // software orders this bit ahead of enable to avoid supply fight
    panel_next.supply_off = ctrl_a_reg.internal_supply_disable;
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_a_reg   <= slc_ctrl_a_t'(RST_CTRL_A);
      ctrl_b_reg   <= slc_ctrl_b_t'(RST_CTRL_B);
      fr_reg       <= slc_frame_rate_t'(RST_FRAME_RATE);
      rdata_reg    <= 32'h00000000;
      wait_reg     <= 1'b1;
      st_reg       <= ST_IDLE;
      phase_reg    <= 3'h0;
      parity_reg   <= 1'b0;
      blank_wc_reg <= 1'b0;
      lp_wc_reg    <= 1'b0;
      irq_reg      <= 1'b0;
      latch_reg    <= 1'b0;
      panel_reg    <= '0;
    end else begin
      ctrl_a_reg   <= ctrl_a_next;
      ctrl_b_reg   <= ctrl_b_next;
      fr_reg       <= fr_next;
      rdata_reg    <= rdata_next;
      wait_reg     <= wait_next;
      st_reg       <= st_next;
      phase_reg    <= phase_next;
      parity_reg   <= parity_next;
      blank_wc_reg <= blank_wc_next;
      lp_wc_reg    <= lp_wc_next;
      irq_reg      <= irq_next;
      latch_reg    <= latch_next;
      panel_reg    <= panel_next;
    end
  end

  assign avs_readdata    = rdata_reg;
  assign avs_waitrequest = wait_reg;
  assign frame_irq       = irq_reg;
  assign data_latch      = latch_reg;
  assign panel           = panel_reg;

  ////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  bus_wait_a: assert property (
    (req && wait_reg) |=> !avs_waitrequest ##1 avs_waitrequest)
    else $error("access not answered after one wait cycle");

  off_now_a: assert property (
    !ctrl_a_reg.controller_enable |=> (panel.seg_en == '0) && (panel.com_en == '0))
    else $error("pins still owned after disable");

  flag_set_a: assert property (
    latch |=> ctrl_a_reg.frame_flag && data_latch)
    else $error("flag not set with data latch");

  irq_gate_a: assert property (
    frame_irq |-> $past(ctrl_a_reg.frame_irq_enable) && $past(global_irq_enable))
    else $error("interrupt without enables");

  flag_w1c_a: assert property (
    (wr_ok && avs_address == ADR_CTRL_A && wr_a.frame_flag && !latch) |=> !ctrl_a_reg.frame_flag)
    else $error("write one did not clear flag");

  lp_skip_a: assert property (
    (boundary && ctrl_a_reg.low_power_waveform_sel && parity_reg) |=> !data_latch)
    else $error("low power latched on odd frame");

  rsv_zero_a: assert property (
    (avs_read && wait_reg && avs_address == ADR_CTRL_B) |=> !avs_readdata[3])
    else $error("reserved bit read as one");

  static_bias_a: assert property (
    (ctrl_b_reg.duty_sel == DUTY_STATIC) |=> (panel.bias == BIAS_STATIC))
    else $error("static duty without static bias");

  seg_mask_a: assert property (
    (st_reg == ST_RUN && ctrl_a_reg.controller_enable && ctrl_b_reg.segment_port_mask == 3'h0)
      |=> (panel.seg_en == 25'h0001FFF))
    else $error("port mask zero wrong segment set");

  start_drive_a: assert property (
    (st_reg == ST_IDLE && ctrl_a_reg.controller_enable)
      |=> (st_reg == ST_RUN) && panel.com_en[0] && panel.seg_en[0])
    else $error("enable did not start driving");

  lp_hold_a: assert property (
    !latch |=> $stable(panel.lp_wave))
    else $error("waveform changed inside a frame");

  blank_hold_a: assert property (
    (!latch && st_reg == ST_RUN && ctrl_a_reg.controller_enable) |=> $stable(panel.blank))
    else $error("blanking changed inside a frame");

  com_count_a: assert property (
    (st_reg == ST_RUN) |-> ($countones(panel.com_en) == $past(ctrl_b_reg.duty_sel) + 3'h1))
    else $error("wrong number of commons driven");

  com_onehot_a: assert property (
    (st_reg == ST_RUN) |-> $onehot(panel.com_sel))
    else $error("active common not one-hot");

endmodule : slc_lcd_ctrl
`default_nettype wire

// ==== slc_pkg.sv ====
/*
  shared constants and types of the segment lcd control block: register
  indices, field layouts, lookup tables and state codes.
  assumes a 32-bit avalon-mm slave with byte addresses of four times the index.
*/
`default_nettype none
package slc_pkg;

  localparam int unsigned ADDR_W = 10;
  localparam int unsigned NSEG   = 25;
  localparam int unsigned NCOM   = 4;
  localparam int unsigned PS_W   = 12;

  // register indices; each register sits in its own aligned word
  localparam logic [7:0] IDX_CTRL_A     = 8'hE4;
  localparam logic [7:0] IDX_CTRL_B     = 8'hE5;
  localparam logic [7:0] IDX_FRAME_RATE = 8'hE6;
  localparam logic [ADDR_W-1:0] ADR_CTRL_A     = {IDX_CTRL_A, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_CTRL_B     = {IDX_CTRL_B, 2'b00};
  localparam logic [ADDR_W-1:0] ADR_FRAME_RATE = {IDX_FRAME_RATE, 2'b00};

  localparam logic [7:0] RST_CTRL_A     = 8'h00;
  localparam logic [7:0] RST_CTRL_B     = 8'h00;
  localparam logic [7:0] RST_FRAME_RATE = 8'h00;
  // reserved bits cleared on every read
  localparam logic [7:0] MASK_CTRL_A     = 8'hDF;
  localparam logic [7:0] MASK_CTRL_B     = 8'hF7;
  localparam logic [7:0] MASK_FRAME_RATE = 8'h77;

  typedef struct packed {
    logic controller_enable;
    logic low_power_waveform_sel;
    logic rsv;
    logic frame_flag;
    logic frame_irq_enable;
    logic buffer_disable;
    logic internal_supply_disable;
    logic blanking;
  } slc_ctrl_a_t;

  typedef struct packed {
    logic       clock_source_sel;
    logic       half_bias_sel;
    logic [1:0] duty_sel;
    logic       rsv;
    logic [2:0] segment_port_mask;
  } slc_ctrl_b_t;

  typedef struct packed {
    logic       rsv_hi;
    logic [2:0] prescaler_tap_sel;
    logic       rsv_lo;
    logic [2:0] clock_divide_sel;
  } slc_frame_rate_t;

  typedef enum logic [1:0] {
    DUTY_STATIC  = 2'b00,
    DUTY_HALF    = 2'b01,
    DUTY_THIRD   = 2'b10,
    DUTY_QUARTER = 2'b11
  } slc_duty_t;

  typedef enum logic [1:0] {
    BIAS_STATIC = 2'b00,
    BIAS_HALF   = 2'b01,
    BIAS_THIRD  = 2'b10
  } slc_bias_t;

  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_RUN  = 1'b1
  } slc_state_t;

  // last phase of a frame of 8 or 6 prescaled periods
  localparam logic [2:0] LAST_K8 = 3'h7;
  localparam logic [2:0] LAST_K6 = 3'h5;
  // phase to common index shift per duty
  localparam logic [1:0] SHIFT_STATIC = 2'h3;
  localparam logic [1:0] SHIFT_HALF   = 2'h2;
  localparam logic [1:0] SHIFT_MULTI  = 2'h1;

  // highest segment driven per port mask code
  localparam logic [4:0] SEG_LAST [0:7] = '{5'h0C, 5'h0E, 5'h10, 5'h12, 5'h14, 5'h16, 5'h17, 5'h18};
  // prescaler tap width, log2 of 16 .. 4096
  localparam logic [3:0] TAP_W [0:7] = '{4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'hA, 4'hB, 4'hC};

  typedef struct packed {
    logic [NSEG-1:0] seg_en;
    logic [NCOM-1:0] com_en;
    logic [NCOM-1:0] com_sel;
    logic            blank;
    logic            lp_wave;
    slc_bias_t       bias;
    logic            buf_off;
    logic            supply_off;
  } slc_panel_t;

endpackage : slc_pkg
`default_nettype wire

// ==== slc_prescaler.sv ====
/*
  prescaler tap and clock divider that make the prescaled panel clock tick.
  assumes lcd_tick is a one-cycle pulse per lcd clock period.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_prescaler (
  input  wire logic       core_clk,
  input  wire logic       rst,
  input  wire logic       run,
  input  wire logic       lcd_tick,
  input  wire logic [2:0] tap_sel,
  input  wire logic [2:0] div_sel,
  output var  logic       ps_tick
);
  import slc_pkg::*;

  logic [PS_W-1:0] cnt_reg,  cnt_next;
  logic [2:0]      div_reg,  div_next;
  logic            tick_reg, tick_next;
  logic [PS_W-1:0] mask;
  logic            tap;

  always_comb begin
    mask      = PS_W'((13'h0001 << TAP_W[tap_sel]) - 13'h0001);
    tap       = lcd_tick && ((cnt_reg & mask) == mask);
    cnt_next  = cnt_reg;
    div_next  = div_reg;
    tick_next = 1'b0;
    if (!run) begin
      cnt_next = '0;
      div_next = '0;
    end else begin
      if (lcd_tick) begin
        cnt_next = cnt_reg + 12'h001;
      end
      if (tap) begin
        if (div_reg >= div_sel) begin
          div_next  = '0;
          tick_next = 1'b1;
        end else begin
          div_next = div_reg + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      cnt_reg  <= '0;
      div_reg  <= '0;
      tick_reg <= 1'b0;
    end else begin
      cnt_reg  <= cnt_next;
      div_reg  <= div_next;
      tick_reg <= tick_next;
    end
  end

  assign ps_tick = tick_reg;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  div_one_a: assert property (
    (run && tap && div_sel == 3'h0) |=> tick_reg)
    else $error("divide by one missed a tick");

endmodule : slc_prescaler
`default_nettype wire

// ==== slc_panel_model.sv ====
/*
  passive multiplexed panel on the common drivers: counts common steps, flags overlap.
  assumes the panel control word of the lcd control block.
*/
`timescale 1ns/1ps
`default_nettype none
module slc_panel_model (
  input  wire logic                core_clk,
  input  wire logic                rst,
  input  wire slc_pkg::slc_panel_t panel,
  output var  logic                fault,
  output var  logic [15:0]         steps
);
  import slc_pkg::*;
  logic [NCOM-1:0] sel_reg, sel_next;
  logic [15:0]     steps_reg, steps_next;
  logic            fault_reg, fault_next;
  ////////////////////////////////////////
  // two commons selected at once would leave dc across the glass
  always_comb begin
    sel_next   = panel.com_sel;
    steps_next = steps_reg + 16'(panel.com_sel != sel_reg);
    fault_next = fault_reg | !$onehot0(panel.com_sel);
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      sel_reg   <= '0;
      steps_reg <= '0;
      fault_reg <= 1'b0;
    end else begin
      sel_reg   <= sel_next;
      steps_reg <= steps_next;
      fault_reg <= fault_next;
    end
  end
  assign fault = fault_reg;
  assign steps = steps_reg;
endmodule : slc_panel_model
`default_nettype wire

// ==== tb_segment_lcd_controller_regs.sv ====
/*
  self-checking bench of the segment lcd control block with a panel model.
  assumes slc_pkg, slc_lcd_ctrl and slc_panel_model are compiled first.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_segment_lcd_controller_regs;
  import slc_pkg::*;
  logic              core_clk = 1'b0;
  logic              rst = 1'b1;
  logic [ADDR_W-1:0] avs_address = '0;
  logic              avs_read = 1'b0;
  logic              avs_write = 1'b0;
  logic [31:0]       avs_writedata = '0;
  logic [3:0]        avs_byteenable = 4'hF;
  logic [31:0]       avs_readdata;
  logic              avs_waitrequest;
  logic              async_clk_in = 1'b0;
  logic              global_irq_enable = 1'b0;
  logic              irq_ack = 1'b0;
  logic              frame_irq;
  logic              data_latch;
  slc_panel_t        panel;
  logic              fault;
  logic [15:0]       steps;
  logic              async_on = 1'b0;
  int                async_div = 0;
  int                fail_count = 0;
  int                checked = 0;
  int                seg_cnt [0:7] = '{13, 15, 17, 19, 21, 23, 24, 25};
  logic [7:0]        fr_code [0:2] = '{8'h10, 8'h02, 8'h27};
  int                fr_len [0:2] = '{512, 384, 8192};

  always #2 core_clk = ~core_clk;
  // async source at a sixth of core_clk, still while unused
  always @(posedge core_clk) begin
    async_div <= (async_div == 2) ? 0 : async_div + 1;
    if (async_div == 2) async_clk_in <= async_on & ~async_clk_in;
  end

  slc_lcd_ctrl dut (
    .core_clk(core_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .async_clk_in(async_clk_in),
    .global_irq_enable(global_irq_enable), .irq_ack(irq_ack), .frame_irq(frame_irq),
    .data_latch(data_latch), .panel(panel));
  slc_panel_model lcd (.core_clk(core_clk), .rst(rst), .panel(panel), .fault(fault), .steps(steps));
  ////////////////////////////////////////
  task automatic complete_run();
    $display("summary checked %0d failed %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  task automatic timeout(input string what);
    fail_count++;
    $display("Error %s expected response seen none", what);
    complete_run();
  endtask : timeout
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %0h seen %0h", what, exp, got);
    end
  endtask : chk
  task automatic chk_cnt(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("Error %s expected %0d seen %0d", what, exp, got);
    end
  endtask : chk_cnt
  task automatic done(input string t);
    $display("test %s done, failures so far %0d", t, fail_count);
  endtask : done
  // request held until waitrequest is sampled low; one idle edge follows
  task automatic bus(input logic rd, input logic [ADDR_W-1:0] a, input logic [7:0] d, output logic [7:0] q);
    int n;
    avs_address   <= a;
    avs_writedata <= {24'h0, d};
    avs_read      <= rd;
    avs_write     <= !rd;
    for (n = 0; n < 20; n++) begin
      @(posedge core_clk);
      if (avs_waitrequest === 1'b0) break;
    end
    q = avs_readdata[7:0];
    avs_read  <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) timeout("waitrequest");
    @(posedge core_clk);
  endtask : bus
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b0, a, d, q);
  endtask : wr
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] q);
    bus(1'b1, a, 8'h00, q);
  endtask : rd
  task automatic wait_latch();
    int n;
    for (n = 0; n < 10000; n++) begin
      @(posedge core_clk);
      if (data_latch === 1'b1) break;
    end
    if (n == 10000) timeout("data_latch");
  endtask : wait_latch
  // cycles and common steps between two latch pulses
  // one edge first so that a frame begun before the last write is skipped
  task automatic frame_len(output int c, output logic [31:0] s);
    logic [15:0] s0;
    @(posedge core_clk);
    wait_latch();
    s0 = steps;
    for (c = 1; c < 10000; c++) begin
      @(posedge core_clk);
      if (data_latch === 1'b1) break;
    end
    s = {16'h0000, steps - s0};
    if (c == 10000) timeout("frame end");
  endtask : frame_len
  ////////////////////////////////////////
  initial begin
    int c, i, d, h;
    logic [31:0] s;
    logic [7:0] q;
    repeat (8) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rd(ADR_CTRL_A, q);
    chk("ctrl_a reset", RST_CTRL_A, q);
    rd(ADR_CTRL_B, q);
    chk("ctrl_b reset", RST_CTRL_B, q);
    rd(ADR_FRAME_RATE, q);
    chk("frame_rate reset", RST_FRAME_RATE, q);
    wr(ADR_CTRL_B, 8'hFF);
    rd(ADR_CTRL_B, q);
    chk("ctrl_b reserved", 8'hF7, q);
    wr(ADR_FRAME_RATE, 8'hFF);
    rd(ADR_FRAME_RATE, q);
    chk("frame_rate reserved", 8'h77, q);
    wr(ADR_CTRL_A, 8'h20);
    rd(ADR_CTRL_A, q);
    chk("ctrl_a reserved", 8'h00, q);
    rd(10'h004, q);
    chk("unmapped read", 8'h00, q);
    avs_byteenable <= 4'h0;
    wr(ADR_CTRL_B, 8'h00);
    avs_byteenable <= 4'hF;
    rd(ADR_CTRL_B, q);
    chk("ctrl_b masked write", 8'hF7, q);
    done("registers");
    wr(ADR_FRAME_RATE, 8'h00);
    wr(ADR_CTRL_B, 8'h37);
    wr(ADR_CTRL_A, 8'h06);
    wr(ADR_CTRL_A, 8'h8E);
    global_irq_enable <= 1'b1;
    wait_latch();
    @(posedge core_clk);
    chk("frame_irq", 1'b1, frame_irq);
    chk("supply_off", 1'b1, panel.supply_off);
    chk("buf_off", 1'b1, panel.buf_off);
    irq_ack <= 1'b1;
    @(posedge core_clk);
    irq_ack <= 1'b0;
    repeat (2) @(posedge core_clk);
    chk("frame_irq after ack", 1'b0, frame_irq);
    rd(ADR_CTRL_A, q);
    chk("flag after ack", 8'h8E, q);
    global_irq_enable <= 1'b0;
    wait_latch();
    @(posedge core_clk);
    chk("frame_irq masked", 1'b0, frame_irq);
    rd(ADR_CTRL_A, q);
    chk("flag at frame", 8'h9E, q);
    wr(ADR_CTRL_A, 8'h8E);
    rd(ADR_CTRL_A, q);
    chk("flag on zero write", 8'h9E, q);
    wr(ADR_CTRL_A, 8'h90);
    rd(ADR_CTRL_A, q);
    chk("flag on one write", 8'h80, q);
    done("interrupt");
    for (d = 0; d < 4; d++) begin
      for (h = 0; h < 2; h++) begin
        wr(ADR_CTRL_B, {1'b0, h[0], d[1:0], 4'h7});
        frame_len(c, s);
        chk_cnt("frame length", (d == 2) ? 96 : 128, c);
        chk_cnt("common steps", (d == 0) ? 0 : d + 1, s);
        chk("com_en", (32'h2 << d) - 1, panel.com_en);
        chk("bias", (d == 0) ? BIAS_STATIC : (h ? BIAS_HALF : BIAS_THIRD), panel.bias);
      end
    end
    for (i = 0; i < 8; i++) begin
      wr(ADR_CTRL_B, 8'h30 | i[7:0]);
      frame_len(c, s);
      chk("seg_en", (32'h1 << seg_cnt[i]) - 1, panel.seg_en);
    end
    done("duty and mask");
    for (i = 0; i < 3; i++) begin
      wr(ADR_FRAME_RATE, fr_code[i]);
      frame_len(c, s);
      chk_cnt("frame length rate", fr_len[i], c);
    end
    wr(ADR_FRAME_RATE, 8'h00);
    wait_latch();
    wr(ADR_CTRL_A, 8'hC0);
    chk("lp_wave held", 1'b0, panel.lp_wave);
    frame_len(c, s);
    chk_cnt("low power frame length", 256, c);
    chk("lp_wave", 1'b1, panel.lp_wave);
    wr(ADR_CTRL_A, 8'h80);
    async_on <= 1'b1;
    wr(ADR_CTRL_B, 8'hB7);
    frame_len(c, s);
    chk_cnt("async frame length", 768, c);
    wr(ADR_CTRL_B, 8'h37);
    async_on <= 1'b0;
    done("rate and clock");
    wait_latch();
    wr(ADR_CTRL_A, 8'h91);
    chk("blank held", 1'b0, panel.blank);
    for (i = 0; i < 400; i++) begin
      rd(ADR_CTRL_A, q);
      if (q[4] === 1'b1) break;
    end
    if (i == 400) timeout("frame flag");
    chk("blank", 1'b1, panel.blank);
    // grounding the freed port pins is left to software
    wr(ADR_CTRL_A, 8'h00);
    repeat (2) @(posedge core_clk);
    chk("seg_en off", 32'h0, panel.seg_en);
    chk("com_en off", 32'h0, panel.com_en);
    c = 0;
    repeat (300) begin
      @(posedge core_clk);
      if (data_latch === 1'b1) c++;
    end
    chk_cnt("latches when off", 0, c);
    chk("panel fault", 1'b0, fault);
    done("shutdown");
    complete_run();
  end
endmodule : tb_segment_lcd_controller_regs
`default_nettype wire
